// ---- design/rwwsp_cfg.svh ----
// rwwsp_cfg.svh: offsets, field positions, reset values and sizes for the self-programming control
// assumes word-addressed flash of 16k words, 64-word pages, 32-bit axi4-lite register bus
`ifndef RWWSP_CFG_SVH
`define RWWSP_CFG_SVH
`define RWWSP_AW 14
`define RWWSP_PAGE_LSB 6
`define RWWSP_STALL_START 14'h3800
`define RWWSP_BOOT_START_0 14'h3800
`define RWWSP_BOOT_START_1 14'h3c00
`define RWWSP_BOOT_START_2 14'h3e00
`define RWWSP_BOOT_START_3 14'h3f00
`define RWWSP_OFF_STATUS 8'h00
`define RWWSP_OFF_LOCK 8'h04
`define RWWSP_OFF_CMD 8'h08
`define RWWSP_OFF_IRQ_STATUS 8'h0c
`define RWWSP_OFF_IRQ_MASK 8'h10
`define RWWSP_OFF_TARGET 8'h14
`define RWWSP_ST_BUSY 0
`define RWWSP_ST_HALT 1
`define RWWSP_ST_ACTIVE 2
`define RWWSP_ST_FUSE_LSB 4
`define RWWSP_LK_APP_NOWRITE 0
`define RWWSP_LK_APP_NOREAD 1
`define RWWSP_LK_BOOT_NOWRITE 2
`define RWWSP_LK_BOOT_NOREAD 3
`define RWWSP_CMD_CLR_BUSY 0
`define RWWSP_IRQ_DONE 0
`define RWWSP_IRQ_REFUSED 1
`define RWWSP_IRQ_LOAD_DENIED 2
`define RWWSP_IRQ_W 3
`define RWWSP_LOCK_RESET 4'h0
`define RWWSP_MASK_RESET 3'h0
`define RWWSP_RESP_OKAY 2'h0
`define RWWSP_RESP_SLVERR 2'h2
`endif

// ---- design/rwwsp_pkg.sv ----
// rwwsp_pkg.sv: types shared by the self-programming control
// assumes rwwsp_cfg.svh supplies the numeric constants
package rwwsp_pkg;
  typedef enum logic {RWWSP_OP_ERASE, RWWSP_OP_WRITE} rwwsp_op_t;
  typedef enum logic [1:0] {RWWSP_IDLE, RWWSP_RUN, RWWSP_RELEASE} rwwsp_state_t;
endpackage

// ---- design/rwwsp_ctrl.sv ----
// rwwsp_ctrl.sv: self-programming control, region checks, flash op sequencing, axi4-lite registers
// assumes cpu and flash macro on aclk; fuse and chip-erase pins asynchronous
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "rwwsp_cfg.svh"
module rwwsp_ctrl (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // cpu program-memory store
  input wire logic program_memory_store_instr,
  input wire logic [`RWWSP_AW-1:0] store_pc,
  input wire logic [`RWWSP_AW-1:0] store_target,
  input wire logic store_is_write,
  // cpu program-memory load
  input wire logic load_valid,
  input wire logic [`RWWSP_AW-1:0] load_pc,
  input wire logic [`RWWSP_AW-1:0] load_addr,
  output logic load_denied,
  // cpu control
  output logic cpu_halt,
  output logic concurrent_read_blocked,
  // flash macro
  output logic flash_start,
  output logic flash_write,
  output logic [`RWWSP_AW-1:0] flash_addr,
  input wire logic flash_done,
  // pins
  input wire logic [1:0] boot_region_size_fuses,
  input wire logic chip_erase,
  input wire logic [3:0] ext_lock_set,
  // interrupt
  output logic irq
);

  rwwsp_pkg::rwwsp_state_t state_reg;
  logic [1:0] fuse_s1_reg, fuse_s2_reg, fuse_reg;
  logic [1:0] fuse_cnt_reg;
  logic erase_s1_reg, erase_s2_reg;
  logic [3:0] lkx_s1_reg, lkx_s2_reg;
  logic [3:0] lock_reg;
  logic busy_reg;
  logic [`RWWSP_IRQ_W-1:0] irq_status_reg, irq_mask_reg, irq_event;
  logic [`RWWSP_AW-1:0] boot_start, target_reg;
  logic pc_in_boot, tgt_in_boot, tgt_in_stall, lock_ok, store_accept, store_refuse;
  logic ld_from_boot, ld_in_boot, ld_deny;
  logic wr_hs, rd_hs, busy_clr;
  logic [31:0] rdata_next;
  logic rresp_err;

  // fuses and lock pins are asynchronous straps: two flops before use
  always_ff @(posedge aclk) begin
    fuse_s1_reg <= boot_region_size_fuses;
    fuse_s2_reg <= fuse_s1_reg;
    erase_s1_reg <= chip_erase;
    erase_s2_reg <= erase_s1_reg;
    lkx_s1_reg <= ext_lock_set;
    lkx_s2_reg <= lkx_s1_reg;
  end

  // fuse size caught once the synchroniser has filled after reset; later changes ignored
  // a fuse change needs a reset to take effect, so the boundary never moves under a running op
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fuse_cnt_reg <= 2'h0;
      fuse_reg <= 2'h0;
    end else if (fuse_cnt_reg != 2'h3) begin
      fuse_cnt_reg <= fuse_cnt_reg + 2'h1;
      fuse_reg <= fuse_s2_reg;
    end
  end

  // boundary per fuse setting; clamped so boot never leaves the stalling region
  always_comb begin
    unique case (fuse_reg)
      2'h0: boot_start = `RWWSP_BOOT_START_0;
      2'h1: boot_start = `RWWSP_BOOT_START_1;
      2'h2: boot_start = `RWWSP_BOOT_START_2;
      2'h3: boot_start = `RWWSP_BOOT_START_3;
    endcase
    if (boot_start < `RWWSP_STALL_START) begin
      boot_start = `RWWSP_STALL_START;
    end
  end

  // region decode; full word addresses compared, page bits only matter to the flash op
  assign pc_in_boot = store_pc >= boot_start;
  assign tgt_in_boot = store_target >= boot_start;
  assign tgt_in_stall = store_target >= `RWWSP_STALL_START;
  assign lock_ok = tgt_in_boot ? !lock_reg[`RWWSP_LK_BOOT_NOWRITE] : !lock_reg[`RWWSP_LK_APP_NOWRITE];
  assign store_accept = program_memory_store_instr && pc_in_boot && lock_ok &&
    state_reg == rwwsp_pkg::RWWSP_IDLE;
  assign store_refuse = program_memory_store_instr && !store_accept;

  // loads across regions gated by the opposite region's read lock
  assign ld_from_boot = load_pc >= boot_start;
  assign ld_in_boot = load_addr >= boot_start;
  assign ld_deny = load_valid && ((ld_from_boot && !ld_in_boot && lock_reg[`RWWSP_LK_APP_NOREAD]) ||
    (!ld_from_boot && ld_in_boot && lock_reg[`RWWSP_LK_BOOT_NOREAD]) ||
    (busy_reg && load_addr < `RWWSP_STALL_START));

  // lock bits only ever set, except by chip erase
  // erase is a level, so locks stay clear for as long as the pin is held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_reg <= `RWWSP_LOCK_RESET;
    end else if (erase_s2_reg) begin
      lock_reg <= `RWWSP_LOCK_RESET;
    end else begin
      lock_reg <= lock_reg | lkx_s2_reg;
      if (wr_hs && s_axi_awaddr == `RWWSP_OFF_LOCK && s_axi_wstrb[0]) begin
        lock_reg <= lock_reg | lkx_s2_reg | s_axi_wdata[3:0];
      end
    end
  end

  // operation sequencer; one page op at a time, stores while running are refused
  // the release cycle refuses stores, so a new op never starts on the done edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= rwwsp_pkg::RWWSP_IDLE;
      target_reg <= '0;
      flash_start <= 1'b0;
      flash_write <= 1'b0;
      cpu_halt <= 1'b0;
    end else begin
      flash_start <= 1'b0;
      unique case (state_reg)
        rwwsp_pkg::RWWSP_IDLE: begin
          if (store_accept) begin
            target_reg <= store_target;
            flash_write <= store_is_write;
            flash_start <= 1'b1;
            cpu_halt <= tgt_in_stall;
            state_reg <= rwwsp_pkg::RWWSP_RUN;
          end
        end
        rwwsp_pkg::RWWSP_RUN: begin
          if (flash_done) begin
            cpu_halt <= 1'b0;
            state_reg <= rwwsp_pkg::RWWSP_RELEASE;
          end
        end
        rwwsp_pkg::RWWSP_RELEASE: begin
          state_reg <= rwwsp_pkg::RWWSP_IDLE;
        end
        default: state_reg <= rwwsp_pkg::RWWSP_IDLE;
      endcase
    end
  end
  assign flash_addr = target_reg;

  // busy flag: set when a concurrent-region op starts, held after done until software clears it while idle
  // no self-clear at op end: concurrent-region code stays untrusted until software re-checks it
  assign busy_clr = wr_hs && s_axi_awaddr == `RWWSP_OFF_CMD && s_axi_wstrb[0] && s_axi_wdata[`RWWSP_CMD_CLR_BUSY] &&
    state_reg == rwwsp_pkg::RWWSP_IDLE;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_reg <= 1'b0;
    end else if (store_accept && !tgt_in_stall) begin
      busy_reg <= 1'b1;
    end else if (busy_clr) begin
      busy_reg <= 1'b0;
    end
  end

  // reads from the stalling region are never gated by busy; only concurrent-region code is blocked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      concurrent_read_blocked <= 1'b0;
      load_denied <= 1'b0;
    end else begin
      concurrent_read_blocked <= (store_accept && !tgt_in_stall) || (busy_reg && !busy_clr);
      load_denied <= ld_deny;
    end
  end

  // sticky events, write one to clear; a new event in the clearing cycle wins
  assign irq_event = {ld_deny, store_refuse, state_reg == rwwsp_pkg::RWWSP_RUN && flash_done};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_reg <= '0;
      irq_mask_reg <= `RWWSP_MASK_RESET;
      irq <= 1'b0;
    end else begin
      if (wr_hs && s_axi_awaddr == `RWWSP_OFF_IRQ_STATUS && s_axi_wstrb[0]) begin
        irq_status_reg <= (irq_status_reg & ~s_axi_wdata[`RWWSP_IRQ_W-1:0]) | irq_event;
      end else begin
        irq_status_reg <= irq_status_reg | irq_event;
      end
      if (wr_hs && s_axi_awaddr == `RWWSP_OFF_IRQ_MASK && s_axi_wstrb[0]) begin
        irq_mask_reg <= s_axi_wdata[`RWWSP_IRQ_W-1:0];
      end
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // axi4-lite write: address and data taken together, response the cycle after
  assign wr_hs = s_axi_awvalid && s_axi_wvalid && s_axi_awready && s_axi_wready;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RWWSP_RESP_OKAY;
    end else begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      if (wr_hs) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (s_axi_awaddr == `RWWSP_OFF_LOCK || s_axi_awaddr == `RWWSP_OFF_CMD ||
          s_axi_awaddr == `RWWSP_OFF_IRQ_STATUS || s_axi_awaddr == `RWWSP_OFF_IRQ_MASK ||
          s_axi_awaddr == `RWWSP_OFF_STATUS || s_axi_awaddr == `RWWSP_OFF_TARGET) ?
          `RWWSP_RESP_OKAY : `RWWSP_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read mux; status and target are read-only, writes to them are dropped
  always_comb begin
    rdata_next = 32'h0000_0000;
    rresp_err = 1'b0;
    unique case (s_axi_araddr)
      `RWWSP_OFF_STATUS: begin
        rdata_next[`RWWSP_ST_BUSY] = busy_reg;
        rdata_next[`RWWSP_ST_HALT] = cpu_halt;
        rdata_next[`RWWSP_ST_ACTIVE] = state_reg != rwwsp_pkg::RWWSP_IDLE;
        rdata_next[`RWWSP_ST_FUSE_LSB +: 2] = fuse_reg;
      end
      `RWWSP_OFF_LOCK: rdata_next[3:0] = lock_reg;
      `RWWSP_OFF_CMD: rdata_next = 32'h0000_0000;
      `RWWSP_OFF_IRQ_STATUS: rdata_next[`RWWSP_IRQ_W-1:0] = irq_status_reg;
      `RWWSP_OFF_IRQ_MASK: rdata_next[`RWWSP_IRQ_W-1:0] = irq_mask_reg;
      `RWWSP_OFF_TARGET: rdata_next[`RWWSP_AW-1:0] = target_reg;
      default: rresp_err = 1'b1;
    endcase
  end

  // axi4-lite read: one outstanding, data the cycle after the address is taken
  // status is registered into rdata, so a read shows the flags one cycle old
  assign rd_hs = s_axi_arvalid && s_axi_arready;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RWWSP_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_hs) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdata_next;
        s_axi_rresp <= rresp_err ? `RWWSP_RESP_SLVERR : `RWWSP_RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ---- tb/rwwsp_checker.sv ----
// rwwsp_checker.sv: port-level checks on the self-programming control
// assumes it is bound into rwwsp_ctrl, one clock aclk, synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
`include "rwwsp_cfg.svh"
module rwwsp_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // cpu side
  input wire logic program_memory_store_instr,
  input wire logic [`RWWSP_AW-1:0] store_pc,
  input wire logic [`RWWSP_AW-1:0] store_target,
  input wire logic store_is_write,
  input wire logic load_valid,
  input wire logic [`RWWSP_AW-1:0] load_addr,
  input wire logic load_denied,
  input wire logic cpu_halt,
  input wire logic concurrent_read_blocked,
  // flash side
  input wire logic flash_start,
  input wire logic flash_write,
  input wire logic [`RWWSP_AW-1:0] flash_addr,
  input wire logic flash_done
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  stall_halt_a: assert property (flash_start && flash_addr >= `RWWSP_STALL_START |-> cpu_halt)
    else $error("stalling op without halt");
  busy_start_a: assert property (flash_start && flash_addr < `RWWSP_STALL_START |->
    concurrent_read_blocked && !cpu_halt)
    else $error("concurrent op not flagged busy or halting");
  halt_hold_a: assert property (cpu_halt && !flash_done |=> cpu_halt)
    else $error("halt dropped before op end");
  halt_release_a: assert property (cpu_halt && flash_done |=> !cpu_halt)
    else $error("halt not released after done");
  app_store_a: assert property (program_memory_store_instr && store_pc < `RWWSP_BOOT_START_0 |=> !flash_start)
    else $error("store from application started op");
  start_cause_a: assert property (flash_start |-> $past(program_memory_store_instr))
    else $error("op started without store");
  addr_capture_a: assert property (flash_start |-> flash_addr == $past(store_target) &&
    flash_write == $past(store_is_write))
    else $error("target or kind not captured");
  addr_hold_a: assert property (!flash_start |-> $stable(flash_addr))
    else $error("captured address moved");
  busy_keep_a: assert property (concurrent_read_blocked && flash_done |=> concurrent_read_blocked)
    else $error("busy flag cleared by op end");
  load_deny_a: assert property (load_valid && load_addr < `RWWSP_STALL_START &&
    concurrent_read_blocked |=> load_denied)
    else $error("load from blocked region served");
  cover property (flash_start && cpu_halt);
  cover property (flash_start && concurrent_read_blocked);
  cover property (load_valid ##1 load_denied);
endmodule
bind rwwsp_ctrl rwwsp_checker u_rwwsp_checker (.aclk, .aresetn, .program_memory_store_instr, .store_pc, .store_target,
  .store_is_write, .load_valid, .load_addr, .load_denied, .cpu_halt, .concurrent_read_blocked, .flash_start,
  .flash_write, .flash_addr, .flash_done);
`default_nettype wire

// ---- tb/rwwsp_flash_model.sv ----
// rwwsp_flash_model.sv: behavioural flash macro ending each page op after a set latency
// assumes the control's clock and reset, lat at least one when flash_start arrives
`timescale 1ns/100ps
`default_nettype none
module rwwsp_flash_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control side
  input wire logic flash_start,
  input wire logic [3:0] lat,
  output logic flash_done
);
  logic [3:0] cnt_reg;
  // a slow part is a larger lat, never a lost pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 4'h0;
      flash_done <= 1'b0;
    end else begin
      flash_done <= (cnt_reg == 4'h1);
      if (flash_start) begin
        cnt_reg <= lat;
      end else if (cnt_reg != 4'h0) begin
        cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/rww_self_programming_control_test.sv ----
// rww_self_programming_control_test.sv: self-checking bench for the self-programming control
// assumes rwwsp_ctrl, the flash model and the bound checker
`timescale 1ns/100ps
`default_nettype none
`include "rwwsp_cfg.svh"
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin num_errors++; \
  $display("FAIL %s exp %0h got %0h", nm, ex, got); end end
module rww_self_programming_control_test;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, program_memory_store_instr = 1'b0, store_is_write = 1'b0;
  logic load_valid = 1'b0, chip_erase = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, load_denied, cpu_halt;
  logic concurrent_read_blocked, flash_start, flash_write, flash_done, irq;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf, ext_lock_set = 4'h0, lat = 4'h1;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp, boot_region_size_fuses = 2'h0;
  logic [13:0] store_pc = 14'h0, store_target = 14'h0, load_pc = 14'h0, load_addr = 14'h0, flash_addr, bs, tg;
  logic [13:0] starts [4] = '{`RWWSP_BOOT_START_0, `RWWSP_BOOT_START_1, `RWWSP_BOOT_START_2, `RWWSP_BOOT_START_3};
  int num_errors = 0, comparisons = 0, cycles = 0, seed = 5;
  rwwsp_ctrl u_rwwsp_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .program_memory_store_instr, .store_pc,
    .store_target, .store_is_write, .load_valid, .load_pc, .load_addr, .load_denied, .cpu_halt,
    .concurrent_read_blocked, .flash_start, .flash_write, .flash_addr, .flash_done, .boot_region_size_fuses,
    .chip_erase, .ext_lock_set, .irq);
  rwwsp_flash_model u_rwwsp_flash_model (.aclk, .aresetn, .flash_start, .lat, .flash_done);
  always #12.5 aclk = ~aclk;
  function automatic logic [31:0] exp_status(input logic [1:0] f, input logic busy);
    return {26'h0, f, 3'h0, busy};
  endfunction
  task automatic end_sim;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      end_sim;
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // the pointer is reused right after the store; the captured address must not follow it
  task automatic store(input logic [13:0] pc, t, input logic w, go);
    program_memory_store_instr <= 1'b1;
    store_pc <= pc;
    store_target <= t;
    store_is_write <= w;
    // latency of 8 or more keeps the done pulse after the loads that run beside a concurrent op
    lat <= 4'(($random(seed) & 7) + 8);
    @(posedge aclk);
    program_memory_store_instr <= 1'b0;
    store_target <= ~t;
    #1;
    `CHK("flash_start", go, flash_start)
    if (go) begin
      `CHK("flash_addr", t, flash_addr)
      `CHK("flash_write", w, flash_write)
      `CHK("cpu_halt", t >= `RWWSP_STALL_START, cpu_halt)
      `CHK("blocked", t < `RWWSP_STALL_START, concurrent_read_blocked)
    end
    @(posedge aclk);
  endtask
  task automatic load(input logic [13:0] a, input logic den);
    load_valid <= 1'b1;
    load_pc <= bs;
    load_addr <= a;
    @(posedge aclk);
    load_valid <= 1'b0;
    #1;
    `CHK("load_denied", den, load_denied)
    @(posedge aclk);
  endtask
  task automatic wait_done;
    do @(posedge aclk); while (flash_done !== 1'b1);
    #1;
    `CHK("halt released", 1'b0, cpu_halt)
    repeat (2) @(posedge aclk);
  endtask
  initial begin
    for (int f = 0; f < 4; f++) begin
      boot_region_size_fuses <= 2'(f);
      aresetn <= 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      bs = starts[f];
      tg = (f == 0) ? 14'h37ff : 14'($random(seed)) & 14'h1fff;
      rd_reg(`RWWSP_OFF_STATUS);
      `CHK("status", exp_status(2'(f), 1'b0), rd)
      rd_reg(8'h40);
      `CHK("unmapped", `RWWSP_RESP_SLVERR, resp)
      store(bs - 14'h1, tg, 1'b1, 1'b0);
      rd_reg(`RWWSP_OFF_IRQ_STATUS);
      `CHK("refused", 32'h2, rd)
      `CHK("irq masked", 1'b0, irq)
      wr(`RWWSP_OFF_IRQ_STATUS, 32'h7);
      wr(`RWWSP_OFF_IRQ_MASK, 32'h1);
      store(bs | (14'($random(seed)) & ~bs), tg, 1'(f), 1'b1);
      load(14'h3900, 1'b0);
      load(tg, 1'b1);
      wait_done;
      rd_reg(`RWWSP_OFF_STATUS);
      `CHK("busy kept", exp_status(2'(f), 1'b1), rd)
      `CHK("irq", 1'b1, irq)
      wr(`RWWSP_OFF_CMD, 32'h1);
      rd_reg(`RWWSP_OFF_STATUS);
      `CHK("busy cleared", exp_status(2'(f), 1'b0), rd)
      load(tg, 1'b0);
      tg = bs | (14'($random(seed)) & ~bs);
      store(bs, tg, 1'(f >> 1), 1'b1);
      wait_done;
      rd_reg(`RWWSP_OFF_TARGET);
      `CHK("target", {18'h0, tg}, rd)
      store(bs, `RWWSP_STALL_START, 1'b1, 1'b1);
      wait_done;
      wr(`RWWSP_OFF_IRQ_STATUS, 32'h7);
      `CHK("irq cleared", 1'b0, irq)
      wr(`RWWSP_OFF_LOCK, 32'h1);
      store(bs, 14'h0040, 1'b1, 1'b0);
      store(bs, bs, 1'b1, 1'b1);
      wait_done;
      wr(`RWWSP_OFF_LOCK, 32'h0);
      `CHK("lock bresp", `RWWSP_RESP_OKAY, resp)
      ext_lock_set <= 4'h4;
      repeat (4) @(posedge aclk);
      ext_lock_set <= 4'h0;
      store(bs, bs, 1'b0, 1'b0);
      rd_reg(`RWWSP_OFF_LOCK);
      `CHK("lock", 32'h5, rd)
      chip_erase <= 1'b1;
      repeat (4) @(posedge aclk);
      chip_erase <= 1'b0;
      repeat (4) @(posedge aclk);
      rd_reg(`RWWSP_OFF_LOCK);
      `CHK("lock erased", 32'h0, rd)
    end
    end_sim;
  end
endmodule
`default_nettype wire
